// ### common/cdl_params.svh
// Purpose: Numeric constants of the comparator, delay and logic combiner.
// Assumes: Included by bare name; definitions only.
// Notes: Offsets are byte addresses on the register bus.
`ifndef CDL_PARAMS_SVH
`define CDL_PARAMS_SVH

// ==========================================================================
// Timing
`define CDL_CLK_PERIOD_NS 25
`define CDL_TICK_NS 100000000
`define CDL_DLY_W 19
`define CDL_DLY_MAX 19'h57E3F
`define CDL_TICK_CNT_W 22

// ==========================================================================
// Register offsets
`define CDL_SET_BASE 12'h000
`define CDL_RES_BASE 12'h020
`define CDL_TMR_BASE 12'h040
`define CDL_DSEL_ADDR 12'h060
`define CDL_CFG_BASE 12'h070
`define CDL_VIEW_ADDR 12'h080
`define CDL_OUTS_ADDR 12'h084

// ==========================================================================
// Field layout of a combiner configuration word
`define CDL_CFG_ORD 0
`define CDL_CFG_SEL1 1
`define CDL_CFG_SEL2 7
`define CDL_CFG_SEL3 13
`define CDL_CFG_SEL4 19
`define CDL_CFG_OP1 25
`define CDL_CFG_OP2 27
`define CDL_CFG_OP3 29
`define CDL_CFG_W 31
`define CDL_SEL_MAX 6'h2B
`define CDL_SEL_LOGIC_PAIR 5'h08

// ==========================================================================
// Reset values
`define CDL_CFG_RST 31'h2A308180
`define CDL_DSEL_W 20
`define CDL_DSEL_RST 20'h18820
`define CDL_DLY_RST 19'h00000

`endif

// ### common/cdl_pkg.sv
// Purpose: Types shared by the comparator and logic combiner files.
// Assumes: The params header is on the include path.
// Notes: Operator codes follow the declaration order of the enum.
`include "cdl_params.svh"

// ==========================================================================
// Types
package cdl_pkg;
  typedef logic [`CDL_DLY_W-1:0] cdl_dly_t;
  typedef enum logic [1:0] {
    CDL_OP_END,
    CDL_OP_AND,
    CDL_OP_OR,
    CDL_OP_XOR
  } cdl_op_t;
  typedef enum logic {
    CDL_ORD_LEFT,
    CDL_ORD_PAIR
  } cdl_order_t;
endpackage : cdl_pkg

// ### rtl/cdl_combiner.sv
// Purpose: One four-input, three-operator logic combiner.
// Assumes: Selection codes in cfg_in were validated before storage.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "cdl_params.svh"

module cdl_combiner (
  // Sources and configuration.
  input wire logic [21:0] src_in,
  input wire logic [`CDL_CFG_W-1:0] cfg_in,
  // Result and live input levels.
  output logic result_out,
  output logic [3:0] view_out
);

  // ==========================================================================
  // Helpers
  // Even codes take a source true, odd codes take it inverted.
  function automatic logic pick(input logic [21:0] src, input logic [5:0] c);
    pick = src[c[5:1]] ^ c[0];
  endfunction : pick

  // Terminate keeps the left operand, which ends the expression except at op1 or op3 in paired order.
  function automatic logic apply(input logic a, input logic b,
                                 input logic [1:0] op);
    case (op)
      cdl_pkg::CDL_OP_AND: apply = a & b;
      cdl_pkg::CDL_OP_OR: apply = a | b;
      cdl_pkg::CDL_OP_XOR: apply = a ^ b;
      default: apply = a;
    endcase
  endfunction : apply

  // ==========================================================================
  // Evaluation
  logic [1:0] op1, op2, op3;
  logic i1, i2, i3, i4, r1, r2, r3, left, right;

  // Four independent selections and three independent operators.
  assign i1 = pick(src_in, cfg_in[`CDL_CFG_SEL1 +: 6]);
  assign i2 = pick(src_in, cfg_in[`CDL_CFG_SEL2 +: 6]);
  assign i3 = pick(src_in, cfg_in[`CDL_CFG_SEL3 +: 6]);
  assign i4 = pick(src_in, cfg_in[`CDL_CFG_SEL4 +: 6]);
  assign op1 = cfg_in[`CDL_CFG_OP1 +: 2];
  assign op2 = cfg_in[`CDL_CFG_OP2 +: 2];
  assign op3 = cfg_in[`CDL_CFG_OP3 +: 2];
  assign view_out = {i4, i3, i2, i1};

  // Left-nested chain.
  assign r1 = apply(i1, i2, op1);
  assign r2 = apply(r1, i3, op2);
  assign r3 = apply(r2, i4, op3);
  // Paired form.
  assign left = apply(i1, i2, op1);
  assign right = apply(i3, i4, op3);

  // A terminate operator stops the left-nested expression at the partial so far; in paired order only op2 stops it, at the left pair.
  always_comb begin
    if (cfg_in[`CDL_CFG_ORD] == cdl_pkg::CDL_ORD_PAIR) begin
      result_out = (op2 == cdl_pkg::CDL_OP_END) ? left
                                                : apply(left, right, op2);
    end else if (op1 == cdl_pkg::CDL_OP_END) begin
      result_out = i1;
    end else if (op2 == cdl_pkg::CDL_OP_END) begin
      result_out = r1;
    end else if (op3 == cdl_pkg::CDL_OP_END) begin
      result_out = r2;
    end else begin
      result_out = r3;
    end
  end

endmodule : cdl_combiner
`default_nettype wire

// ### rtl/cdl_comparator_logic.sv
// Purpose: Delayed comparators and logic combiners behind an APB slave.
// Assumes: All inputs are synchronous to CLK_IN; APB with zero wait states.
// Notes: Combiner results are registered, so feedback has no loop.
//
// Function
// - Analogue comparator rise waits programmable set delay, default zero.
// - Analogue comparator fall waits separate reset delay, default zero.
// - Each analogue delay timer's elapsed value is readable only.
// - Four identical analogue channels, each with own delays and timer.
// - Digital comparator output follows its selected status input.
// - Digital comparator activation waits programmable set delay.
// - Digital comparator deactivation waits its own reset delay.
// - Digital comparator timer value is readable, never writable.
// - Four digital comparators; defaults operation, input one, trip, ready.
// - Combiner inputs are all comparator, logic, timer, flop, counter bits.
// - Operators are AND, OR and exclusive-OR of two operands.
// - Combiner results drive relay and virtual connection outputs.
// - Expression view shows live levels of the four selected inputs.
// - Bracket order: zero left-nested by default, one paired.
// - Left-nested: ((in1 op1 in2) op2 in3) op3 in4.
// - Paired: (in1 op1 in2) op2 (in3 op3 in4).
// - Four independent input selections and three independent operators.
// - Operator codes: 0 terminate, 1 AND, 2 OR, 3 XOR.
// - Input codes 0 to 43, true then inverted, starting analogue one.
// - A combiner refuses its own output as one of its inputs.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cdl_params.svh"

module cdl_comparator_logic #(
  parameter int unsigned TICK_CYCLES = `CDL_TICK_NS / `CDL_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // APB slave.
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Internal signal sources.
  input wire logic [3:0] ANALOG_RAW_IN,
  input wire logic [31:0] STATUS_IN,
  input wire logic [3:0] LOGIC_TIMER_IN,
  input wire logic [3:0] FLIPFLOP_IN,
  input wire logic [1:0] COUNTER_IN,
  // Results toward relays and virtual connections.
  output logic [3:0] ANALOG_CMP_OUT,
  output logic [3:0] DIGITAL_CMP_OUT,
  output logic [3:0] LOGIC_RESULT_OUT
);

  // ==========================================================================
  // Address constants
  localparam logic [11:0] set_base = `CDL_SET_BASE;
  localparam logic [11:0] res_base = `CDL_RES_BASE;
  localparam logic [11:0] tmr_base = `CDL_TMR_BASE;
  localparam logic [11:0] dsel_addr = `CDL_DSEL_ADDR;
  localparam logic [11:0] cfg_base = `CDL_CFG_BASE;
  localparam logic [11:0] view_addr = `CDL_VIEW_ADDR;
  localparam logic [11:0] outs_addr = `CDL_OUTS_ADDR;
  localparam logic [`CDL_TICK_CNT_W-1:0] tick_last =
    `CDL_TICK_CNT_W'(TICK_CYCLES - 1);

  // ==========================================================================
  // Storage
  cdl_pkg::cdl_dly_t set_dly_ff [8];
  cdl_pkg::cdl_dly_t res_dly_ff [8];
  cdl_pkg::cdl_dly_t timer_w [8];
  logic [`CDL_DSEL_W-1:0] dsel_ff;
  logic [`CDL_CFG_W-1:0] cfg_ff [4];
  logic [3:0] view_w [4];
  logic [3:0] comb_w;
  logic [3:0] logic_result_ff;
  logic [7:0] raw_w;
  logic [7:0] dly_out_w;
  logic [21:0] src_w;
  logic [`CDL_TICK_CNT_W-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff, nxt_pslverr;
  logic wr_commit;

  // ==========================================================================
  // Tenth-second tick
  // A free-running divider keeps all eight timers on one time base.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == tick_last) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + `CDL_TICK_CNT_W'(1);
      tick_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Comparator delay channels
  // Channels 0 to 3 are analogue, 4 to 7 digital.
  // Digital comparators take the selected status bit as their raw level.
  // One process drives the whole vector, so no bit has two drivers.
  always_comb begin
    raw_w[3:0] = ANALOG_RAW_IN;
    for (int i = 0; i < 4; i++) begin
      raw_w[4+i] = STATUS_IN[dsel_ff[5*i +: 5]];
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_chan
    // Same channel logic serves all eight comparators.
    cdl_delay_chan u_chan (
      .clk_in(CLK_IN),
      .rst_in(RESET_IN),
      .tick_in(tick_ff),
      .raw_in(raw_w[g]),
      .set_dly_in(set_dly_ff[g]),
      .reset_dly_in(res_dly_ff[g]),
      .out_out(dly_out_w[g]),
      .timer_out(timer_w[g])
    );
  end

  assign ANALOG_CMP_OUT = dly_out_w[3:0];
  assign DIGITAL_CMP_OUT = dly_out_w[7:4];

  // ==========================================================================
  // Logic combiners
  // Source order matches the selection code pairs.
  assign src_w = {COUNTER_IN, FLIPFLOP_IN, LOGIC_TIMER_IN, logic_result_ff,
                  dly_out_w[7:4], dly_out_w[3:0]};

  for (genvar k = 0; k < 4; k++) begin : g_comb
    cdl_combiner u_comb (
      .src_in(src_w),
      .cfg_in(cfg_ff[k]),
      .result_out(comb_w[k]),
      .view_out(view_w[k])
    );
  end

  // The register breaks the path from a result back into other combiners.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      logic_result_ff <= 4'h0;
    end else begin
      logic_result_ff <= comb_w;
    end
  end

  assign LOGIC_RESULT_OUT = logic_result_ff;

  // ==========================================================================
  // Write validation
  // A combiner word is refused if any code is out of range or names itself.
  function automatic logic cfg_ok(input logic [31:0] d, input logic [1:0] k);
    logic ok;
    logic [5:0] s;
    ok = !d[31];
    for (int j = 0; j < 4; j++) begin
      s = d[`CDL_CFG_SEL1 + 6*j +: 6];
      if (s > `CDL_SEL_MAX) begin
        ok = 1'b0;
      end
      if (s[5:1] == (`CDL_SEL_LOGIC_PAIR + {3'h0, k})) begin
        ok = 1'b0;
      end
    end
    cfg_ok = ok;
  endfunction : cfg_ok

  function automatic logic dly_ok(input logic [31:0] d);
    dly_ok = (d[31:`CDL_DLY_W] == '0) && (d[`CDL_DLY_W-1:0] <= `CDL_DLY_MAX);
  endfunction : dly_ok

  // ==========================================================================
  // APB decode in the setup phase
  // Read data and error are prepared during setup so the ports come
  // straight from flops; the cost is one fixed access cycle.
  always_comb begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (PADDR_IN[1:0] != 2'h0) begin
      nxt_pslverr = 1'b1;
    end else if (PADDR_IN[11:5] == set_base[11:5]) begin
      nxt_prdata = {13'h0000, set_dly_ff[PADDR_IN[4:2]]};
      nxt_pslverr = PWRITE_IN && !dly_ok(PWDATA_IN);
    end else if (PADDR_IN[11:5] == res_base[11:5]) begin
      nxt_prdata = {13'h0000, res_dly_ff[PADDR_IN[4:2]]};
      nxt_pslverr = PWRITE_IN && !dly_ok(PWDATA_IN);
    end else if (PADDR_IN[11:5] == tmr_base[11:5]) begin
      nxt_prdata = {13'h0000, timer_w[PADDR_IN[4:2]]};
      nxt_pslverr = PWRITE_IN;
    end else if (PADDR_IN == dsel_addr) begin
      nxt_prdata = {12'h000, dsel_ff};
      nxt_pslverr = PWRITE_IN && (PWDATA_IN[31:`CDL_DSEL_W] != '0);
    end else if (PADDR_IN[11:4] == cfg_base[11:4]) begin
      nxt_prdata = {1'b0, cfg_ff[PADDR_IN[3:2]]};
      nxt_pslverr = PWRITE_IN && !cfg_ok(PWDATA_IN, PADDR_IN[3:2]);
    end else if (PADDR_IN == view_addr) begin
      nxt_prdata = {16'h0000, view_w[3], view_w[2], view_w[1], view_w[0]};
      nxt_pslverr = PWRITE_IN;
    end else if (PADDR_IN == outs_addr) begin
      nxt_prdata = {20'h00000, logic_result_ff, dly_out_w};
      nxt_pslverr = PWRITE_IN;
    end else begin
      nxt_pslverr = 1'b1;
    end
  end

  // Ready rises for exactly the access cycle after each setup cycle.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= PSEL_IN && !PENABLE_IN;
      if (PSEL_IN && !PENABLE_IN) begin
        pslverr_ff <= nxt_pslverr;
        prdata_ff <= PWRITE_IN ? 32'h00000000 : nxt_prdata;
      end else begin
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h00000000;
      end
    end
  end

  assign PREADY_OUT = pready_ff;
  assign PSLVERR_OUT = pslverr_ff;
  assign PRDATA_OUT = prdata_ff;

  // A refused write changes nothing.
  assign wr_commit = PSEL_IN && PENABLE_IN && pready_ff && PWRITE_IN &&
                     !pslverr_ff;

  // ==========================================================================
  // Delay settings
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < 8; i++) begin
        set_dly_ff[i] <= `CDL_DLY_RST;
        res_dly_ff[i] <= `CDL_DLY_RST;
      end
    end else if (wr_commit) begin
      if (PADDR_IN[11:5] == set_base[11:5]) begin
        set_dly_ff[PADDR_IN[4:2]] <= PWDATA_IN[`CDL_DLY_W-1:0];
      end
      if (PADDR_IN[11:5] == res_base[11:5]) begin
        res_dly_ff[PADDR_IN[4:2]] <= PWDATA_IN[`CDL_DLY_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Digital comparator selections
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      dsel_ff <= `CDL_DSEL_RST;
    end else if (wr_commit && PADDR_IN == dsel_addr) begin
      dsel_ff <= PWDATA_IN[`CDL_DSEL_W-1:0];
    end
  end

  // ==========================================================================
  // Combiner configuration
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < 4; i++) begin
        cfg_ff[i] <= `CDL_CFG_RST;
      end
    end else if (wr_commit && PADDR_IN[11:4] == cfg_base[11:4]) begin
      cfg_ff[PADDR_IN[3:2]] <= PWDATA_IN[`CDL_CFG_W-1:0];
    end
  end

  // ==========================================================================
  // Checks
  // A bus write is judged at the access edge, where it would take effect.
  chk_self_reject: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (PSEL_IN && PENABLE_IN && pready_ff && PWRITE_IN &&
     PADDR_IN == cfg_base && PWDATA_IN[`CDL_CFG_SEL1+1 +: 5] == 5'h08)
    |-> pslverr_ff ##1 $stable(cfg_ff[0]))
    else $error("self selection was accepted");
  chk_timer_ro: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (PSEL_IN && PENABLE_IN && pready_ff && PWRITE_IN &&
     PADDR_IN[11:5] == tmr_base[11:5]) |-> pslverr_ff)
    else $error("timer write was accepted");
  chk_dly_range: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (PSEL_IN && PENABLE_IN && pready_ff && PWRITE_IN &&
     PADDR_IN[11:5] == set_base[11:5] &&
     PWDATA_IN > {13'h0000, `CDL_DLY_MAX}) |-> pslverr_ff)
    else $error("out of range delay was accepted");
  chk_sel_range: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (PSEL_IN && PENABLE_IN && pready_ff && PWRITE_IN &&
     PADDR_IN[11:4] == cfg_base[11:4] &&
     PWDATA_IN[`CDL_CFG_SEL1 +: 6] > `CDL_SEL_MAX) |-> pslverr_ff)
    else $error("out of range selection was accepted");
  // A committed write to a set delay must leave that delay equal to its data.
  chk_dly_store: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (wr_commit && PADDR_IN[11:5] == set_base[11:5]) |=>
    set_dly_ff[$past(PADDR_IN[4:2])] == $past(PWDATA_IN[`CDL_DLY_W-1:0]))
    else $error("set delay write was lost");
  chk_and_chain: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (cfg_ff[0][`CDL_CFG_OP1 +: 6] == 6'h15)
    |=> logic_result_ff[0] == &$past(view_w[0]))
    else $error("AND combination wrong");
  chk_xor_parity: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (cfg_ff[0][`CDL_CFG_OP1 +: 6] == 6'h3F)
    |=> logic_result_ff[0] == ^$past(view_w[0]))
    else $error("XOR combination wrong");
  chk_left_or: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (cfg_ff[0][`CDL_CFG_OP1 +: 6] == 6'h19 &&
     !cfg_ff[0][`CDL_CFG_ORD])
    |=> logic_result_ff[0] == (((($past(view_w[0]) & 4'h3) == 4'h3) ||
                                $past(view_w[0][2])) && $past(view_w[0][3])))
    else $error("left-nested order wrong");
  chk_apb_ready: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (PSEL_IN && !PENABLE_IN) |=> pready_ff ##1 !pready_ff)
    else $error("ready not exactly one access cycle");
  chk_dig_follow: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (set_dly_ff[4] == 19'h00000 && raw_w[4] && !dly_out_w[4])
    |=> dly_out_w[4])
    else $error("digital comparator did not follow input");

endmodule : cdl_comparator_logic
`default_nettype wire

// ### rtl/cdl_delay_chan.sv
// Purpose: One comparator output with separate set and reset delays.
// Assumes: tick_in is a one-cycle pulse every tenth of a second.
// Notes: The timer shows elapsed ticks of the pending transition.
`timescale 1ns/1ps
`default_nettype none
`include "cdl_params.svh"

module cdl_delay_chan (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Timing and settings.
  input wire logic tick_in,
  input wire logic raw_in,
  input wire cdl_pkg::cdl_dly_t set_dly_in,
  input wire cdl_pkg::cdl_dly_t reset_dly_in,
  // Delayed output and timer.
  output logic out_out,
  output cdl_pkg::cdl_dly_t timer_out
);

  // ==========================================================================
  // Delay state
  logic out_ff;
  cdl_pkg::cdl_dly_t timer_ff;
  cdl_pkg::cdl_dly_t target;

  // A rising change waits for the set delay, a falling one for the reset.
  assign target = raw_in ? set_dly_in : reset_dly_in;

  // Timer counts ticks while the input disagrees; agreement cancels it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_ff <= 1'b0;
      timer_ff <= `CDL_DLY_RST;
    end else if (raw_in == out_ff) begin
      timer_ff <= `CDL_DLY_RST;
    end else if (timer_ff >= target) begin
      out_ff <= raw_in;
      timer_ff <= `CDL_DLY_RST;
    end else if (tick_in) begin
      timer_ff <= timer_ff + 19'h00001;
    end
  end

  assign out_out = out_ff;
  assign timer_out = timer_ff;

  // ==========================================================================
  // Checks
  chk_set_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (!out_ff && raw_in && timer_ff < set_dly_in) |=> !out_ff)
    else $error("output rose before set delay");
  chk_reset_done: assert property (@(posedge clk_in) disable iff (rst_in)
    (out_ff && !raw_in && timer_ff >= reset_dly_in) |=> !out_ff)
    else $error("output did not fall after reset delay");
  chk_cancel_pend: assert property (@(posedge clk_in) disable iff (rst_in)
    (raw_in == out_ff) |=> (timer_ff == 19'h00000 && out_ff == $past(out_ff)))
    else $error("pending transition not cancelled");
  chk_timer_step: assert property (@(posedge clk_in) disable iff (rst_in)
    (raw_in != out_ff && timer_ff < target && tick_in)
    |=> timer_ff == $past(timer_ff) + 19'h00001)
    else $error("timer did not advance on tick");

endmodule : cdl_delay_chan
`default_nettype wire

// ### verif/cdl_relay_model.sv
// Purpose: Relay and virtual connection side of the combiner results.
// Assumes: Results are levels synchronous to clk_in.
// Notes: Latches each result on every rising clock edge, as a relay driver would.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Relay model
module cdl_relay_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Combiner results and relay states.
  input wire logic [3:0] logic_in,
  output logic [3:0] relay_out
);
  // Relays follow the results one clock late; reset opens them all.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      relay_out <= 4'h0;
    end else begin
      relay_out <= logic_in;
    end
  end
endmodule : cdl_relay_model
`default_nettype wire

// ### verif/test_cdl_comparator_logic.sv
// Purpose: Self-checking bench of the comparator and combiner block.
// Assumes: Tick shortened to 4 clocks.
// Notes: Bus answers are checked against queued notes by a monitor.
`timescale 1ns/1ps
`default_nettype none
`include "cdl_params.svh"

// ==========================================================================
// Bench
module test_cdl_comparator_logic;
  logic clk, rst, psel, pen, pwr, prdy, perr, ord, left, right, r;
  logic [11:0] padr;
  logic [31:0] pwd, prd, stat;
  logic [3:0] araw, tmr, ff, aout, dout, lout, relay, l;
  logic [1:0] ctr;
  logic [5:0] ops;
  logic [5:0] sel [4];
  logic [64:0] notes [$];
  logic [64:0] note_q;
  int error_cnt, num_checks;

  cdl_comparator_logic #(.TICK_CYCLES(4)) u_dut (
    .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .ANALOG_RAW_IN(araw),
    .STATUS_IN(stat), .LOGIC_TIMER_IN(tmr), .FLIPFLOP_IN(ff),
    .COUNTER_IN(ctr), .ANALOG_CMP_OUT(aout), .DIGITAL_CMP_OUT(dout),
    .LOGIC_RESULT_OUT(lout));
  cdl_relay_model u_relay (.clk_in(clk), .rst_in(rst), .logic_in(lout),
    .relay_out(relay));

  // Level of a directly driven source code; odd codes are inverted.
  function automatic logic lvl(input logic [5:0] c);
    logic [9:0] v;
    v = {ctr, ff, tmr};
    return v[c / 2 - 12] ^ c[0];
  endfunction : lvl

  // A terminating operator passes its first operand on unchanged.
  function automatic logic opf(input logic [1:0] o, input logic a,
                               input logic b);
    case (o)
      2'h1: return a & b;
      2'h2: return a | b;
      2'h3: return a ^ b;
      default: return a;
    endcase
  endfunction : opf

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One bus transfer; the request is held until ready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic e,
                     input logic [31:0] x, input logic [31:0] m);
    notes.push_back({m, e, x});
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic e);
    apb(1'b1, a, d, e, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic [31:0] m, input logic e);
    apb(1'b0, a, 32'h0, e, x, m);
  endtask : rd

  task automatic test_done;
    if (notes.size() != 0) begin
      error_cnt++;
    end
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Answers are matched against the oldest note as they appear.
  always @(posedge clk) begin
    if (prdy === 1'b1) begin
      if (notes.size() == 0) begin
        chk("spare answer", 32'h0, 32'h1);
      end else begin
        note_q = notes.pop_front();
        chk("error flag", {31'h0, note_q[32]}, {31'h0, perr});
        chk("read data", note_q[31:0] & note_q[64:33], prd & note_q[64:33]);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The whole run needs about 500 clocks; a hang is cut off well after.
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  initial begin
    {rst, psel, pen, pwr, padr, pwd, stat, araw, tmr, ff, ctr} = '0;
    rst = 1'b1;
    void'($urandom(32'hC2C4EB93));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`CDL_SET_BASE, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(`CDL_RES_BASE + 12'h01C, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(`CDL_DSEL_ADDR, 32'h00018820, 32'hFFFFFFFF, 1'b0);
    rd(`CDL_CFG_BASE + 12'h00C, 32'h2A308180, 32'hFFFFFFFF, 1'b0);
    rd(12'h0FC, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(`CDL_TMR_BASE + 12'h010, 32'h1, 1'b1);
    wr(`CDL_SET_BASE, 32'd360000, 1'b1);
    wr(`CDL_SET_BASE + 12'h004, 32'd359999, 1'b0);
    rd(`CDL_SET_BASE + 12'h004, 32'd359999, 32'hFFFFFFFF, 1'b0);
    // Channel two goes back to no delay for the follow checks below.
    wr(`CDL_SET_BASE + 12'h004, 32'h0, 1'b0);
    wr(`CDL_CFG_BASE, 32'h2A3081A0, 1'b1);
    wr(`CDL_CFG_BASE, 32'h2A3081D8, 1'b1);
    wr(`CDL_SET_BASE, 32'h2, 1'b0);
    wr(`CDL_RES_BASE, 32'h3, 1'b0);
    // Two ticks of set delay, then three of reset delay with a revert.
    araw <= 4'h1;
    repeat (4) @(posedge clk);
    chk("analogue out", 32'h0, {31'h0, aout[0]});
    repeat (12) @(posedge clk);
    chk("analogue out", 32'h1, {31'h0, aout[0]});
    araw <= 4'h0;
    repeat (4) @(posedge clk);
    chk("analogue out", 32'h1, {31'h0, aout[0]});
    araw <= 4'h1;
    repeat (20) @(posedge clk);
    chk("analogue out", 32'h1, {31'h0, aout[0]});
    rd(`CDL_TMR_BASE, 32'h0, 32'hFFFFFFFF, 1'b0);
    araw <= 4'h0;
    repeat (20) @(posedge clk);
    chk("analogue out", 32'h0, {31'h0, aout[0]});
    for (int i = 0; i < 8; i++) begin
      stat <= $urandom;
      araw[3:1] <= 3'($urandom);
      repeat (3) @(posedge clk);
      chk("digital out", {28'h0, stat[3:0]}, {28'h0, dout});
      chk("analogue out", {29'h0, araw[3:1]}, {29'h0, aout[3:1]});
    end
    // Random expressions over the directly driven sources.
    for (int i = 0; i < 40; i++) begin
      tmr <= 4'($urandom);
      ff <= 4'($urandom);
      ctr <= 2'($urandom);
      for (int k = 0; k < 4; k++) sel[k] = 6'(24 + $urandom_range(19));
      // The first passes pin down the all-XOR and AND-OR-AND forms.
      ops = (i == 0) ? 6'h3F : (i == 1) ? 6'h19 : 6'($urandom);
      ord = (i < 2) ? 1'b0 : 1'($urandom);
      wr(`CDL_CFG_BASE, {1'b0, ops, sel[3], sel[2], sel[1], sel[0], ord},
         1'b0);
      repeat (3) @(posedge clk);
      for (int k = 0; k < 4; k++) l[k] = lvl(sel[k]);
      left = opf(ops[1:0], l[0], l[1]);
      right = opf(ops[5:4], l[2], l[3]);
      if (ord) r = opf(ops[3:2], left, right);
      else if (ops[1:0] == 2'h0) r = l[0];
      else if (ops[3:2] == 2'h0) r = left;
      else r = opf(ops[5:4], opf(ops[3:2], left, l[2]), l[3]);
      chk("combiner", {31'h0, r}, {31'h0, lout[0]});
      chk("relay state", {31'h0, r}, {31'h0, relay[0]});
      rd(`CDL_VIEW_ADDR, {28'h0, l}, 32'h0000000F, 1'b0);
    end
    // Let the monitor take the last answer before the queue is judged.
    @(posedge clk);
    test_done();
  end
endmodule : test_cdl_comparator_logic
`default_nettype wire
